// [verilog/bpup_parser.sv]
// Boot page update parser: receives page writes and answers them
// Overview of operation
// - The address query is answered only while in bootloader mode, proving that mode.
// - A page write holds page index, encoding marker, block index, then a 64-byte slice.
// - The bootloader flash region is never written, even by a broken session.
// - The target address is page index times 1024 plus block index times 64.
// - Page index must be 1 to 27, keeping writes within 0x0400 to 0x6FFF.
// - Block index must be 0 to 15, sixteen slices to a page.
// - The debug port accepts only a full chip erase and refuses all else.
// - A length byte leads, counting all later bytes including the checksum.
// - Header bytes 0x4E 0x41 and control type 0xCD follow; deviants are dropped silently.
// - The last byte is the XOR of all before it; mismatches are dropped silently.
// - Write is 0x01, acknowledge 0x81, page complete 0x02; replies carry the page index.
`timescale 1ns/1ps
`include "bpup_consts.svh"
module bpup_parser
  import bpup_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic boot_mode,
  input wire logic [63:0] hw_address,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  input wire logic dbg_valid,
  input wire logic [7:0] dbg_cmd,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic flash_en,
  output logic [14:0] flash_addr,
  output logic [7:0] flash_data,
  output logic chip_erase,
  output logic dbg_refused
);
  typedef enum logic [2:0] {
    BPUP_IDLE, BPUP_HDR, BPUP_BODY, BPUP_CHECK, BPUP_REPLY, BPUP_DONE
  } bpup_state_type;

  function automatic logic page_ok(input logic [7:0] p);
    page_ok = (p >= `BPUP_PAGE_MIN) && (p <= `BPUP_PAGE_MAX);
  endfunction

  bpup_state_type state;
  logic [7:0] remain;
  logic [6:0] pos;
  logic [7:0] csum;
  logic [7:0] cmd;
  logic [7:0] page;
  logic [7:0] slice;
  logic [7:0] enc;
  logic [7:0] slice_buf [0:63];
  logic [15:0] page_done_mask;
  logic [7:0] mask_page;
  logic [6:0] wr_idx;
  logic tx_start;
  logic [7:0] tx_cmd;
  logic [7:0] tx_arg;
  logic tx_busy;
  logic send_done;
  bpup_byte_type tx_out;
  logic mode_s1;
  logic mode_s2;

  // Mode pin is asynchronous
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end else begin
      mode_s1 <= boot_mode;
      mode_s2 <= mode_s1;
    end
  end

  wire rx_take = rx_valid;
  wire [7:0] next_csum = csum ^ rx_data;
  wire last_byte = (remain == 8'd1);
  wire hdr_bad = (pos == 7'd0 && rx_data != `BPUP_HDR_N) ||
                 (pos == 7'd1 && rx_data != `BPUP_HDR_A) ||
                 (pos == 7'd2 && rx_data != `BPUP_CTRL_TYPE);
  wire is_write = (cmd == `BPUP_CMD_WRITE);
  wire is_query = (cmd == `BPUP_CMD_ADDR_QUERY);
  wire len_ok = is_write ? (pos == 7'd71) : (is_query ? (pos == 7'd4) : 1'b1);
  wire range_ok = page_ok(page) && (slice <= `BPUP_SLICE_MAX) &&
                  (enc == `BPUP_ENC_MARK);
  wire [14:0] base_addr = 15'({page[4:0], 10'h000}) + 15'({slice[3:0], 6'h00});
  wire [15:0] next_mask = ((mask_page == page) ? page_done_mask : 16'h0000) |
                          (16'h0001 << slice[3:0]);
  wire page_full = (next_mask == 16'hFFFF);

  bpup_tx u_tx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(tx_start),
    .cmd(tx_cmd),
    .arg(tx_arg),
    .hw_address(hw_address),
    .tx_ready(tx_ready),
    .tx_out(tx_out),
    .busy(tx_busy)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= BPUP_IDLE;
      remain <= '0;
      pos <= '0;
      csum <= '0;
      cmd <= '0;
      page <= '0;
      slice <= '0;
      enc <= '0;
      page_done_mask <= '0;
      mask_page <= '0;
      wr_idx <= '0;
      tx_start <= 1'b0;
      tx_cmd <= '0;
      tx_arg <= '0;
      send_done <= 1'b0;
      flash_en <= 1'b0;
      flash_addr <= '0;
      flash_data <= '0;
    end else begin
      tx_start <= 1'b0;
      flash_en <= 1'b0;
      case (state)
        BPUP_IDLE: if (rx_take && rx_data != 8'h00) begin
          remain <= rx_data;
          csum <= rx_data;
          pos <= '0;
          state <= BPUP_HDR;
        end
        BPUP_HDR, BPUP_BODY: if (rx_take) begin
          remain <= remain - 8'd1;
          pos <= pos + 7'd1;
          csum <= next_csum;
          if (last_byte) begin
            // Bad frame counted to its end, so its tail is never read as a length
            state <= (state == BPUP_HDR && !hdr_bad && next_csum == 8'h00 && len_ok) ?
                     BPUP_CHECK : BPUP_IDLE;
          end else begin
            if (hdr_bad) begin
              state <= BPUP_BODY;
            end
            case (pos)
              7'd3: cmd <= rx_data;
              7'd4: page <= rx_data;
              7'd5: enc <= rx_data;
              7'd6: slice <= rx_data;
              default: if (pos >= 7'd7 && pos < 7'd71) begin
                slice_buf[6'(pos - 7'd7)] <= rx_data;
              end
            endcase
          end
        end
        BPUP_CHECK: begin
          wr_idx <= '0;
          if (!mode_s2) begin
            state <= BPUP_IDLE;
          end else if (is_query) begin
            tx_cmd <= `BPUP_CMD_ADDR_REPLY;
            state <= BPUP_REPLY;
          end else if (is_write && range_ok) begin
            tx_cmd <= `BPUP_CMD_ACK;
            tx_arg <= page;
            state <= BPUP_DONE;
          end else begin
            tx_cmd <= `BPUP_CMD_UNSUPP;
            tx_arg <= `BPUP_ERR_PROTO;
            state <= BPUP_REPLY;
          end
        end
        BPUP_DONE: begin
          // Addresses below 0x0400 unreachable: page_ok guards the write
          flash_en <= 1'b1;
          flash_addr <= base_addr + 15'(wr_idx);
          flash_data <= slice_buf[wr_idx[5:0]];
          wr_idx <= wr_idx + 7'd1;
          if (wr_idx == 7'd63) begin
            mask_page <= page;
            page_done_mask <= page_full ? 16'h0000 : next_mask;
            send_done <= page_full;
            state <= BPUP_REPLY;
          end
        end
        BPUP_REPLY: begin
          if (tx_busy && send_done) begin
            // Framer has latched the ack; only now may the command change
            send_done <= 1'b0;
            tx_cmd <= `BPUP_CMD_DONE;
          end else if (!tx_busy && !tx_start) begin
            tx_start <= 1'b1;
            state <= send_done ? BPUP_REPLY : BPUP_IDLE;
          end
        end
        default: state <= BPUP_IDLE;
      endcase
    end
  end

  // Output registers mirror the framer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
    end else begin
      tx_valid <= tx_out.valid;
      tx_data <= tx_out.data;
    end
  end

  // Debug port: only a complete erase is honoured
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chip_erase <= 1'b0;
      dbg_refused <= 1'b0;
    end else begin
      chip_erase <= dbg_valid && (dbg_cmd == `BPUP_DBG_ERASE);
      dbg_refused <= dbg_valid && (dbg_cmd != `BPUP_DBG_ERASE);
    end
  end
endmodule

// [verilog/bpup_consts.svh]
// Constants for the boot page update parser
`ifndef BPUP_CONSTS_SVH
`define BPUP_CONSTS_SVH
`define BPUP_HDR_N 8'h4E
`define BPUP_HDR_A 8'h41
`define BPUP_CTRL_TYPE 8'hCD
`define BPUP_CMD_WRITE 8'h01
`define BPUP_CMD_ACK 8'h81
`define BPUP_CMD_DONE 8'h02
`define BPUP_CMD_ADDR_QUERY 8'h05
`define BPUP_CMD_ADDR_REPLY 8'h85
`define BPUP_CMD_UNSUPP 8'h09
`define BPUP_ERR_PROTO 8'h01
`define BPUP_PAGE_MIN 8'h01
`define BPUP_PAGE_MAX 8'h1B
`define BPUP_SLICE_MAX 8'h0F
`define BPUP_SLICE_BYTES 7'h40
`define BPUP_WRITE_LEN 8'h48
`define BPUP_QUERY_LEN 8'h05
`define BPUP_ADDR_BYTES 4'h8
`define BPUP_DBG_ERASE 8'h14
`define BPUP_ENC_MARK 8'h01
`define BPUP_REPLY_LEN 8'h06
`define BPUP_ADDR_REPLY_LEN 8'h0D
`endif

// [verilog/bpup_pkg.sv]
// Types for the boot page update parser
package bpup_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bpup_byte_type;
  typedef struct packed {
    logic en;
    logic [14:0] addr;
    logic [7:0] data;
  } bpup_flash_type;
endpackage

// [verilog/bpup_tx.sv]
// Reply packet framer with running checksum
`timescale 1ns/1ps
`include "bpup_consts.svh"
module bpup_tx
  import bpup_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] cmd,
  input wire logic [7:0] arg,
  input wire logic [63:0] hw_address,
  input wire logic tx_ready,
  output bpup_byte_type tx_out,
  output logic busy
);
  logic [4:0] idx;
  logic [4:0] last;
  logic [7:0] cmd_q;
  logic [7:0] arg_q;
  logic [7:0] csum;
  logic [7:0] cur;
  logic is_addr;
  // Length counts every byte after itself, checksum included
  wire [7:0] len = is_addr ? `BPUP_ADDR_REPLY_LEN : `BPUP_REPLY_LEN;
  wire [2:0] addr_sel = 3'(idx - 5'd5);
  always_comb begin
    case (idx)
      5'd0: cur = len;
      5'd1: cur = `BPUP_HDR_N;
      5'd2: cur = `BPUP_HDR_A;
      5'd3: cur = `BPUP_CTRL_TYPE;
      5'd4: cur = cmd_q;
      default: cur = (idx == last) ? csum : (is_addr ? hw_address[8*addr_sel +: 8] : arg_q);
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      tx_out <= '0;
      idx <= '0;
      csum <= '0;
      cmd_q <= '0;
      arg_q <= '0;
      is_addr <= 1'b0;
      last <= '0;
    end else if (!busy) begin
      tx_out.valid <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cmd_q <= cmd;
        arg_q <= arg;
        is_addr <= (cmd == `BPUP_CMD_ADDR_REPLY);
        last <= (cmd == `BPUP_CMD_ADDR_REPLY) ? 5'd13 : 5'd6;
        idx <= '0;
        csum <= '0;
      end
    end else if (!tx_out.valid || tx_ready) begin
      tx_out.valid <= 1'b1;
      tx_out.data <= cur;
      csum <= csum ^ cur;
      idx <= idx + 5'd1;
      if (idx == last) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// [testbench/bpup_host.sv]
// Host model: frames packets, gathers reply bytes
`timescale 1ns/1ps
`include "bpup_consts.svh"
module bpup_host (
  input wire logic sys_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [7:0] rsp[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  always @(posedge sys_clk) if (tx_valid) rsp.push_back(tx_data);
  task automatic put(input logic [7:0] b);
    @(negedge sys_clk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    // Idle line must not repeat the last byte
    rx_data = ~b;
  endtask
  // Flip spoils the checksum on purpose
  task automatic send(input logic [7:0] body[$], input logic [7:0] ct, input logic [7:0] flip);
    logic [7:0] cs;
    logic [7:0] f[$];
    f = {`BPUP_HDR_N, `BPUP_HDR_A, ct};
    f = {f, body};
    f.push_front(8'(f.size() + 1));
    cs = 8'h00;
    foreach (f[i]) cs ^= f[i];
    f.push_back(cs ^ flip);
    rsp.delete();
    foreach (f[i]) put(f[i]);
  endtask
endmodule

// [testbench/bpup_parser_chk.sv]
// Port checker for the boot page update parser
`timescale 1ns/1ps
`include "bpup_consts.svh"
module bpup_parser_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic boot_mode,
  input wire logic tx_valid,
  input wire logic flash_en,
  input wire logic [14:0] flash_addr,
  input wire logic dbg_valid,
  input wire logic [7:0] dbg_cmd,
  input wire logic chip_erase,
  input wire logic dbg_refused
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_burst; flash_en [*8]; endsequence
  property p_range; flash_en |-> flash_addr >= 15'h0400 && flash_addr <= 15'h6FFF; endproperty
  a_range: assert property (p_range) else $error("flash write out of area");
  property p_align; $rose(flash_en) |-> flash_addr[5:0] == 6'h00; endproperty
  a_align: assert property (p_align) else $error("slice start misaligned");
  property p_step; flash_en && $past(flash_en) |-> flash_addr == $past(flash_addr) + 15'h0001; endproperty
  a_step: assert property (p_step) else $error("flash address skipped");
  property p_burst; $rose(flash_en) |-> s_burst; endproperty
  a_burst: assert property (p_burst) else $error("slice burst broken");
  property p_erase; dbg_valid && dbg_cmd == `BPUP_DBG_ERASE |=> chip_erase && !dbg_refused; endproperty
  a_erase: assert property (p_erase) else $error("erase not taken");
  property p_refuse; dbg_valid && dbg_cmd != `BPUP_DBG_ERASE |=> dbg_refused && !chip_erase; endproperty
  a_refuse: assert property (p_refuse) else $error("debug command not refused");
  property p_boot; !boot_mode [*8] |-> !flash_en && !tx_valid; endproperty
  a_boot: assert property (p_boot) else $error("activity outside boot mode");
  property p_quiet; flash_en |-> !tx_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("reply during flash burst");
endmodule
bind bpup_parser bpup_parser_chk i_bpup_parser_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .boot_mode(boot_mode), .tx_valid(tx_valid), .flash_en(flash_en), .flash_addr(flash_addr),
  .dbg_valid(dbg_valid), .dbg_cmd(dbg_cmd), .chip_erase(chip_erase), .dbg_refused(dbg_refused));

// [testbench/bpup_parser_tb.sv]
// Self-checking bench for the boot page update parser
`timescale 1ns/1ps
`include "bpup_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module bpup_parser_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic boot_mode = 1'b1;
  logic [63:0] hw_address = 64'h0123456789ABCDEF; // Arbitrary value
  logic dbg_valid = 1'b0;
  logic [7:0] dbg_cmd = 8'h00;
  logic rx_valid, tx_ready, tx_valid, flash_en, chip_erase, dbg_refused;
  logic [7:0] rx_data, tx_data, flash_data;
  logic [14:0] flash_addr;
  logic [7:0] mem [0:32767];
  int mismatches = 0;
  int cmp_count = 0;
  int nflash = 0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (flash_en) mem[flash_addr] <= flash_data;
  always @(posedge sys_clk) nflash <= nflash + int'(flash_en);
  bpup_parser i_bpup_parser (.sys_clk(sys_clk), .rst_n(rst_n), .boot_mode(boot_mode),
    .hw_address(hw_address), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .dbg_valid(dbg_valid), .dbg_cmd(dbg_cmd), .tx_valid(tx_valid), .tx_data(tx_data),
    .flash_en(flash_en), .flash_addr(flash_addr), .flash_data(flash_data),
    .chip_erase(chip_erase), .dbg_refused(dbg_refused));
  bpup_host i_bpup_host (.sys_clk(sys_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_rsp(input int n);
    int k;
    for (k = 0; k < 600 && i_bpup_host.rsp.size() < n; k++) @(negedge sys_clk);
    if (k == 600) begin
      mismatches++;
      end_of_test();
    end
    // Long enough for a wrongly queued extra reply to show up
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic chk_rsp(input logic [7:0] cmd, input logic [7:0] arg, input int o);
    logic [7:0] cs;
    wait_rsp(o + 7);
    cs = 8'h00;
    for (int i = o; i < o + 7; i++) cs ^= i_bpup_host.rsp[i];
    `CHK(i_bpup_host.rsp[o], 8'h06)
    `CHK(i_bpup_host.rsp[o + 1], `BPUP_HDR_N)
    `CHK(i_bpup_host.rsp[o + 3], `BPUP_CTRL_TYPE)
    `CHK(i_bpup_host.rsp[o + 4], cmd)
    `CHK(i_bpup_host.rsp[o + 5], arg)
    `CHK(cs, 8'h00)
  endtask
  // Image byte that lands at offset i of a slice
  function automatic logic [7:0] img(input logic [7:0] pg, input logic [7:0] sl, input int i);
    return 8'(1024 - 64 * sl - i) ^ pg;
  endfunction
  task automatic write(input logic [7:0] pg, input logic [7:0] sl, input logic [7:0] en);
    logic [7:0] b[$];
    b = {`BPUP_CMD_WRITE, pg, en, sl};
    for (int i = 0; i < 64; i++) b.push_back(img(pg, sl, i));
    i_bpup_host.send(b, `BPUP_CTRL_TYPE, 8'h00);
  endtask
  task automatic t_query();
    logic [7:0] cs;
    i_bpup_host.send({`BPUP_CMD_ADDR_QUERY}, `BPUP_CTRL_TYPE, 8'h00);
    wait_rsp(14);
    `CHK(i_bpup_host.rsp[0], 8'h0D)
    `CHK(i_bpup_host.rsp[4], `BPUP_CMD_ADDR_REPLY)
    for (int i = 0; i < 8; i++) `CHK(i_bpup_host.rsp[5 + i], hw_address[8 * i +: 8])
    cs = 8'h00;
    foreach (i_bpup_host.rsp[i]) cs ^= i_bpup_host.rsp[i];
    `CHK(cs, 8'h00)
    $display("test query done");
  endtask
  // Off mode, wrong control type, spoilt checksum: all silent
  task automatic t_silent();
    for (int c = 0; c < 3; c++) begin
      boot_mode = (c != 0);
      repeat (4) @(negedge sys_clk);
      i_bpup_host.send({`BPUP_CMD_ADDR_QUERY}, (c == 1) ? 8'hCC : `BPUP_CTRL_TYPE,
        (c == 2) ? 8'h01 : 8'h00);
      repeat (60) @(posedge sys_clk);
      `CHK(i_bpup_host.rsp.size(), 0)
    end
    $display("test silent done");
  endtask
  task automatic t_range();
    logic [23:0] bad[4] = '{24'h000001, 24'h1C0001, 24'h011001, 24'h010002};
    int n0;
    n0 = nflash;
    foreach (bad[i]) begin
      write(bad[i][23:16], bad[i][15:8], bad[i][7:0]);
      chk_rsp(`BPUP_CMD_UNSUPP, `BPUP_ERR_PROTO, 0);
    end
    `CHK(nflash, n0)
    $display("test range done");
  endtask
  // Top page, slices in reverse order, then bottom page
  task automatic t_page();
    for (int s = 15; s >= 0; s--) begin
      write(8'h1B, 8'(s), 8'h01);
      chk_rsp(`BPUP_CMD_ACK, 8'h1B, 0);
      if (s == 0) chk_rsp(`BPUP_CMD_DONE, 8'h1B, 7);
      else `CHK(i_bpup_host.rsp.size(), 7)
    end
    for (int a = 0; a < 1024; a++) `CHK(mem[15'h6C00 + a], img(8'h1B, 8'(a / 64), a % 64))
    write(8'h01, 8'h00, 8'h01);
    chk_rsp(`BPUP_CMD_ACK, 8'h01, 0);
    `CHK(mem[15'h043F], img(8'h01, 8'h00, 63))
    $display("test page done");
  endtask
  task automatic t_debug();
    @(negedge sys_clk);
    dbg_valid = 1'b1;
    dbg_cmd = `BPUP_DBG_ERASE;
    @(negedge sys_clk);
    `CHK(chip_erase, 1'b1)
    dbg_cmd = 8'h3C;
    @(negedge sys_clk);
    `CHK(dbg_refused, 1'b1)
    `CHK(chip_erase, 1'b0)
    dbg_valid = 1'b0;
    $display("test debug done");
  endtask
  // Host gives up on a mute device: reset, boot mode again, restart at slice 0
  task automatic t_restart();
    int n0;
    n0 = i_bpup_host.rsp.size();
    i_bpup_host.put(8'h48);
    i_bpup_host.put(`BPUP_HDR_N);
    repeat (20) @(negedge sys_clk);
    `CHK(i_bpup_host.rsp.size(), n0)
    rst_n = 1'b0;
    boot_mode = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    boot_mode = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_query();
    write(8'h02, 8'h00, 8'h01);
    chk_rsp(`BPUP_CMD_ACK, 8'h02, 0);
    `CHK(mem[15'h0800], img(8'h02, 8'h00, 0))
    $display("test restart done");
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_query();
    t_silent();
    t_range();
    t_page();
    t_debug();
    t_restart();
    end_of_test();
  end
endmodule
